// >>> src/wdk_pkg.sv
`default_nettype none

package wdk_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] MASTER_ADDR = 8'hf0;
  localparam logic [7:0] KEY_ADDR = 8'hf1;

  // Master register fields
  localparam int ENABLE_BIT = 7;
  localparam int PERIOD_LSB = 5;
  localparam int HALT_LSB = 3;
  localparam logic [2:0] RSVD_READ = 3'h7;
  localparam logic [1:0] PERIOD_RESET = 2'h3;
  localparam logic [1:0] HALT_RESET = 2'h3;

  // Second-key command values and unmapped read value
  localparam logic [7:0] KEY_DISABLE = 8'h01;
  localparam logic [7:0] KEY_CLEAR = 8'h45;
  localparam logic [7:0] UNMAPPED_READ = 8'hff;

  // ****************************************
  // Timing
  // ****************************************
  localparam int PERIOD_BASE_BITS = 16;
  localparam int PERIOD_STEP_BITS = 2;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0]
  {
    HALT_IDLE_ONE = 2'h0,
    HALT_IDLE_TWO = 2'h1,
    HALT_STOP = 2'h2,
    HALT_RUN = 2'h3
  } wdk_halt_mode_type;

  typedef enum logic [1:0]
  {
    ST_ACTIVE = 2'h1,
    ST_HALTED = 2'h2
  } wdk_state_type;

  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wdk_io_req_type;

  typedef struct packed
  {
    logic osc_run;
    logic system_clock_output;
    logic cpu_clk;
    logic ctc_clk;
    logic pio_sio_clk;
    logic wdog_clk;
  } wdk_clk_gate_type;

endpackage : wdk_pkg

`default_nettype wire

// >>> src/wdk_counter.sv
`timescale 1ns/1ps
`default_nettype none

module wdk_counter
#(
  parameter int BASE_BITS = wdk_pkg::PERIOD_BASE_BITS
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic run,
  input wire logic clr,
  input wire logic [1:0] sel,
  output logic expire
);

  localparam int CW = BASE_BITS + 3 * wdk_pkg::PERIOD_STEP_BITS;

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] last;
  logic expire_q;
  logic expire_d;

  // Period grows by a factor of four per select step
  assign last = (CW'(1) << (BASE_BITS + wdk_pkg::PERIOD_STEP_BITS * 32'(sel)))
    - CW'(1);

  always_comb
  begin
    cnt_d = cnt_q;
    expire_d = 1'b0;
    if (clr || !run)
    begin
      cnt_d = '0;
    end
    else if (cnt_q >= last)
    begin
      cnt_d = '0;
      expire_d = 1'b1;
    end
    else
    begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      cnt_q <= '0;
      expire_q <= 1'b0;
    end
    else if (ce)
    begin
      cnt_q <= cnt_d;
      expire_q <= expire_d;
    end
  end

  assign expire = expire_q;

endmodule : wdk_counter

`default_nettype wire

// >>> src/wdk_watchdog.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Master register at F0h, key command register at F1h in I/O space.
// - Writing enable bit one with period starts watchdog, no key needed.
// - Stop only after enable written zero, then key 01h written.
// - Writing the clear key restarts the watchdog count.
// - Key register is write-only; reading it changes nothing.
// - Watchdog never raises an interrupt; only the timeout output.
// - Period select field resets to 11.
// - Halt mode changes only on master write after key 01h.
// - Halt mode 00 idle-one, 01 idle-two, 10 stop, 11 run; resets run.
// - Reserved master bits are written 011 and always read 111.
// - Master write alone can never disable supervision.
// - Idle-one halt: oscillator and counter/timer clock run, clock output and other internal clocks stop.
// - Idle-two halt: oscillator, counter/timer, clock output keep running.
// - Stop halt: oscillator, clock output and all internal clocks stop.
module wdk_watchdog
#(
  parameter int BASE_BITS = wdk_pkg::PERIOD_BASE_BITS
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire wdk_pkg::wdk_io_req_type io_req,
  output logic [7:0] io_rdata,
  input wire logic halt_fetch_t4,
  input wire logic halt_exit,
  output wdk_pkg::wdk_clk_gate_type clk_gate,
  output logic [1:0] halt_power_mode_field,
  output logic wdog_enable_flag,
  output logic wdog_timeout
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  logic master_wr;
  logic key_wr;
  logic master_rd;

  assign master_wr = io_req.wr && hit(io_req.addr, wdk_pkg::MASTER_ADDR);
  assign key_wr = io_req.wr && hit(io_req.addr, wdk_pkg::KEY_ADDR);
  assign master_rd = io_req.rd && hit(io_req.addr, wdk_pkg::MASTER_ADDR);

  // ****************************************
  // Master register and double key
  // ****************************************
  logic en_q, en_d;
  logic dis_req_q, dis_req_d;
  logic halt_arm_q, halt_arm_d;
  logic [1:0] period_q, period_d;
  logic [1:0] halt_q, halt_d;
  logic [7:0] rdata_q, rdata_d;
  logic clr_pulse;

  always_comb
  begin
    en_d = en_q;
    dis_req_d = dis_req_q;
    halt_arm_d = halt_arm_q;
    period_d = period_q;
    halt_d = halt_q;
    clr_pulse = 1'b0;
    rdata_d = rdata_q;
    if (master_wr)
    begin
      period_d = io_req.wdata[wdk_pkg::PERIOD_LSB +: 2];
      if (io_req.wdata[wdk_pkg::ENABLE_BIT])
      begin
        if (!en_q)
        begin
          clr_pulse = 1'b1;
        end
        en_d = 1'b1;
        dis_req_d = 1'b0;
      end
      else
      begin
        // Zero only arms the stop; runaway code cannot finish it alone
        dis_req_d = 1'b1;
      end
      if (halt_arm_q)
      begin
        halt_d = io_req.wdata[wdk_pkg::HALT_LSB +: 2];
      end
      halt_arm_d = 1'b0;
    end
    else if (key_wr)
    begin
      if (io_req.wdata == wdk_pkg::KEY_DISABLE)
      begin
        halt_arm_d = 1'b1;
        if (dis_req_q)
        begin
          en_d = 1'b0;
          dis_req_d = 1'b0;
        end
      end
      else if (io_req.wdata == wdk_pkg::KEY_CLEAR)
      begin
        clr_pulse = 1'b1;
      end
    end
    if (io_req.rd)
    begin
      // Key register and unmapped reads return a constant, no side effect
      rdata_d = master_rd
        ? {en_q, period_q, halt_q, wdk_pkg::RSVD_READ}
        : wdk_pkg::UNMAPPED_READ;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      en_q <= 1'b0;
      dis_req_q <= 1'b0;
      halt_arm_q <= 1'b0;
      period_q <= wdk_pkg::PERIOD_RESET;
      halt_q <= wdk_pkg::HALT_RESET;
      rdata_q <= '0;
    end
    else if (ce)
    begin
      en_q <= en_d;
      dis_req_q <= dis_req_d;
      halt_arm_q <= halt_arm_d;
      period_q <= period_d;
      halt_q <= halt_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // Halt power-down control
  // ****************************************
  wdk_pkg::wdk_state_type state_q, state_d;
  wdk_pkg::wdk_clk_gate_type gate_q, gate_d;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      wdk_pkg::ST_ACTIVE:
      begin
        if (halt_fetch_t4)
        begin
          state_d = wdk_pkg::ST_HALTED;
        end
      end
      wdk_pkg::ST_HALTED:
      begin
        if (halt_exit)
        begin
          state_d = wdk_pkg::ST_ACTIVE;
        end
      end
      default:
      begin
        state_d = wdk_pkg::ST_ACTIVE;
      end
    endcase
    gate_d = '1;
    if (state_d == wdk_pkg::ST_HALTED)
    begin
      unique case (wdk_pkg::wdk_halt_mode_type'(halt_q))
        wdk_pkg::HALT_IDLE_ONE:
        begin
          gate_d = '0;
          gate_d.osc_run = 1'b1;
          gate_d.ctc_clk = 1'b1;
        end
        wdk_pkg::HALT_IDLE_TWO:
        begin
          gate_d = '0;
          gate_d.osc_run = 1'b1;
          gate_d.ctc_clk = 1'b1;
          gate_d.system_clock_output = 1'b1;
        end
        wdk_pkg::HALT_STOP:
        begin
          gate_d = '0;
        end
        wdk_pkg::HALT_RUN:
        begin
          gate_d = '1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      state_q <= wdk_pkg::ST_ACTIVE;
      gate_q <= '1;
    end
    else if (ce)
    begin
      state_q <= state_d;
      gate_q <= gate_d;
    end
  end

  // ****************************************
  // Timeout counter
  // ****************************************
  // Frozen with the watchdog clock during a gated halt
  wdk_counter #(
    .BASE_BITS(BASE_BITS)
  ) u_counter (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce && gate_q.wdog_clk),
    .run(en_q),
    .clr(clr_pulse && ce),
    .sel(period_q),
    .expire(wdog_timeout)
  );

  assign io_rdata = rdata_q;
  assign clk_gate = gate_q;
  assign halt_power_mode_field = halt_q;
  assign wdog_enable_flag = en_q;

endmodule : wdk_watchdog

`default_nettype wire

// >>> tb/wdk_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker
// ****
module wdk_monitor (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire wdk_pkg::wdk_io_req_type io_req,
  input wire logic [7:0] io_rdata,
  input wire logic halt_fetch_t4,
  input wire logic halt_exit,
  input wire wdk_pkg::wdk_clk_gate_type clk_gate,
  input wire logic [1:0] halt_power_mode_field,
  input wire logic wdog_enable_flag,
  input wire logic wdog_timeout
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  property p_pulse;
    wdog_timeout && ce && clk_gate.wdog_clk |=> !wdog_timeout;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_on;
    $rose(wdog_enable_flag) |->
      $past(io_req.wr && io_req.addr == 8'hf0 && io_req.wdata[7]);
  endproperty
  a_on: assert property (p_on) else $error("bad enable");
  // Reset release is not a key event
  property p_off;
    $fell(wdog_enable_flag) && $past(nrst) |->
      $past(io_req.wr && io_req.addr == 8'hf1 && io_req.wdata == 8'h01);
  endproperty
  a_off: assert property (p_off) else $error("bad disable");
  property p_mode;
    $changed(halt_power_mode_field) && $past(nrst) |->
      $past(io_req.wr && io_req.addr == 8'hf0);
  endproperty
  a_mode: assert property (p_mode) else $error("bad mode");
  property p_keyrd;
    io_req.rd && ce && io_req.addr == 8'hf1 |=> io_rdata == 8'hff;
  endproperty
  a_keyrd: assert property (p_keyrd) else $error("key read");
  property p_rsvd;
    io_req.rd && ce && io_req.addr == 8'hf0 |=> io_rdata[2:0] == 3'h7;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved");
  property p_idle_one_mode;
    halt_fetch_t4 && ce && halt_power_mode_field == 2'h0 |=>
      clk_gate == 6'h24;
  endproperty
  a_idle_one_mode: assert property (p_idle_one_mode) else $error("idle one");
  property p_stop;
    halt_fetch_t4 && ce && halt_power_mode_field == 2'h2 |=>
      clk_gate == 6'h00;
  endproperty
  a_stop: assert property (p_stop) else $error("stop");
  property p_idle_two_mode;
    halt_fetch_t4 && ce && halt_power_mode_field == 2'h1 |=>
      clk_gate == 6'h34;
  endproperty
  a_idle_two_mode: assert property (p_idle_two_mode) else $error("idle two");
endmodule : wdk_monitor
bind wdk_watchdog wdk_monitor u_wdk_monitor (.mclk, .nrst, .ce, .io_req,
  .io_rdata, .halt_fetch_t4, .halt_exit, .clk_gate,
  .halt_power_mode_field, .wdog_enable_flag, .wdog_timeout);
`default_nettype wire

// >>> tb/wdk_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Host I/O cycles
// ****
module wdk_host (
  input wire logic mclk,
  input wire logic [7:0] io_rdata,
  output var wdk_pkg::wdk_io_req_type io_req
);
  initial io_req = '0;
  // Released lines show the inverse, never a stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    io_req <= '{a, d, 1'h1, 1'h0};
    @(posedge mclk);
    io_req <= '{~a, ~d, 1'h0, 1'h0};
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    io_req <= '{a, 8'h00, 1'h0, 1'h1};
    @(posedge mclk);
    io_req <= '{~a, 8'hff, 1'h0, 1'h0};
    #1;
    d = io_rdata;
  endtask : rd
  task automatic wr_m(input logic e, input logic [1:0] p, logic [1:0] h);
    wr(8'hf0, {e, p, h, 3'h3});
  endtask : wr_m
endmodule : wdk_host
`default_nettype wire

// >>> tb/tb_wdk_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h seen %h", n, e, s); end end
module tb_wdk_watchdog;
  logic mclk = 1'h0;
  logic nrst = 1'h0;
  logic ce = 1'h1;
  logic hlt = 1'h0;
  logic wake = 1'h0;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [1:0] mode;
  logic en;
  logic tmo;
  int errors = 0;
  int cmp_count = 0;
  int n_tmo = 0;
  wdk_pkg::wdk_io_req_type io_req;
  wdk_pkg::wdk_clk_gate_type clk_gate;
  // ****
  // Harness
  // ****
  wdk_host u_wdk_host (.mclk, .io_rdata(rdata), .io_req);
  // Short base count keeps periods at 4..256 cycles
  wdk_watchdog #(.BASE_BITS(2)) u_wdk_watchdog (.mclk, .nrst, .ce, .io_req,
    .io_rdata(rdata), .halt_fetch_t4(hlt), .halt_exit(wake), .clk_gate,
    .halt_power_mode_field(mode), .wdog_enable_flag(en), .wdog_timeout(tmo));
  initial forever #5 mclk = ~mclk;
  always @(negedge mclk) if (tmo === 1'h1) n_tmo++;
  task automatic report_and_stop;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic t_reset;
    `CHK("enable", 1'h0, en)
    `CHK("mode", 2'h3, mode)
    `CHK("gates", 6'h3f, clk_gate)
    u_wdk_host.rd(8'hf0, d);
    `CHK("master", 8'h7f, d)
    u_wdk_host.rd(8'hf1, d);
    `CHK("key read", 8'hff, d)
    u_wdk_host.rd(8'h10, d);
    `CHK("unmapped", 8'hff, d)
  endtask : t_reset
  task automatic t_enable;
    int k;
    u_wdk_host.wr_m(1'h1, 2'h0, 2'h0);
    `CHK("enable", 1'h1, en)
    `CHK("mode kept", 2'h3, mode)
    k = n_tmo;
    for (int i = 0; i < 10; i++)
      u_wdk_host.wr(8'hf1, 8'h45);
    `CHK("cleared", k, n_tmo)
    u_wdk_host.rd(8'hf0, d);
    `CHK("master", 8'h9f, d)
    for (int i = 0; i < 9 && n_tmo == k; i++)
      @(posedge mclk);
    `CHK("expired", k + 1, n_tmo)
  endtask : t_enable
  task automatic t_disable;
    int k;
    u_wdk_host.wr_m(1'h0, 2'h0, 2'h3);
    `CHK("still on", 1'h1, en)
    u_wdk_host.wr(8'hf1, 8'h22);
    `CHK("other key", 1'h1, en)
    u_wdk_host.wr(8'hf1, 8'h01);
    `CHK("off", 1'h0, en)
    k = n_tmo;
    repeat (20) @(posedge mclk);
    `CHK("silent", k, n_tmo)
  endtask : t_disable
  task automatic t_halt;
    logic [5:0] g [4] = '{6'h24, 6'h34, 6'h00, 6'h3f};
    for (int m = 3; m < 7; m++)
    begin
      u_wdk_host.wr(8'hf1, 8'h01);
      u_wdk_host.wr_m(1'h0, 2'h3, m[1:0]);
      `CHK("mode", m[1:0], mode)
      @(posedge mclk);
      hlt <= 1'h1;
      @(posedge mclk);
      hlt <= 1'h0;
      #1;
      `CHK("gates", g[m[1:0]], clk_gate)
      @(posedge mclk);
      wake <= 1'h1;
      @(posedge mclk);
      wake <= 1'h0;
      #1;
      `CHK("wake", 6'h3f, clk_gate)
    end
  endtask : t_halt
  // Low enable must hold the count, so no pulse while frozen
  task automatic t_freeze;
    int k;
    u_wdk_host.wr_m(1'h1, 2'h0, 2'h0);
    @(posedge mclk);
    ce <= 1'h0;
    k = n_tmo;
    repeat (12) @(posedge mclk);
    `CHK("frozen", k, n_tmo)
    `CHK("held on", 1'h1, en)
    ce <= 1'h1;
    for (int i = 0; i < 9 && n_tmo == k; i++)
      @(posedge mclk);
    `CHK("resumed", k + 1, n_tmo)
  endtask : t_freeze
  initial
  begin
    repeat (6) @(posedge mclk);
    nrst <= 1'h1;
    t_reset();
    t_enable();
    t_disable();
    t_halt();
    t_freeze();
    u_wdk_host.wr_m(1'h1, 2'h2, 2'h0);
    @(posedge mclk);
    nrst <= 1'h0;
    repeat (6) @(posedge mclk);
    nrst <= 1'h1;
    t_reset();
    report_and_stop();
  end
endmodule : tb_wdk_watchdog
`default_nettype wire
